// ### inc/tgw_map.svh
// Purpose: Offsets, field positions, reset values and counts of the timer group.
// Assumes: 8-bit APB byte address, one 32-bit word per register.
// Notes: Rule summary follows.
`ifndef TGW_MAP_SVH
`define TGW_MAP_SVH
`define TGW_TCFG 5'h00
`define TGW_TLDL 5'h04
`define TGW_TLDH 5'h08
`define TGW_TALL 5'h0c
`define TGW_TALH 5'h10
`define TGW_TCNL 5'h14
`define TGW_TCNH 5'h18
`define TGW_TCFG_MASK 32'hffff_001f
`define TGW_WCFG 5'h00
`define TGW_WTO0 5'h04
`define TGW_WFEED 5'h14
`define TGW_WPROT 5'h18
`define TGW_WSTAT 5'h1c
`define TGW_WCFG_MASK 32'h0000_1fff
`define TGW_INT_ST 8'he0
`define TGW_INT_MSK 8'he4
`define TGW_WKEY 32'h5a5a_c3c3
`define TGW_BOOT_CFG_SYS 13'h0063
`define TGW_BOOT_CFG_CORE 13'h0043
`define TGW_BOOT_TO_NS 64'd20000000
`endif

// ### inc/tgw_pkg.sv
// Purpose: Types shared by the timer group.
// Assumes: Nothing beyond the map header.
// Notes: Action codes sit two bits per stage in the watchdog configuration.
package tgw_pkg;
    typedef enum logic [1:0] {
        TGW_ACT_INT = 2'b00,
        TGW_ACT_CPU = 2'b01,
        TGW_ACT_CORE = 2'b10,
        TGW_ACT_SYS = 2'b11
    } tgw_act_t;
endpackage

// ### verilog/tgw_timer_group_watchdog.sv
// Purpose: Four 64-bit timers, three four-stage watchdogs and their APB registers.
// Assumes: One clock pclk at 100 MHz; flash_boot_pin is an asynchronous strap.
// Notes: Watchdogs 0 and 1 are the main ones, watchdog 2 the always-on one.
`timescale 1ns/1ps
`include "tgw_map.svh"
module tgw_timer_group_watchdog #(
    parameter int CLK_MHZ = 100,
    parameter logic [31:0] BOOT_TO = 32'((`TGW_BOOT_TO_NS * CLK_MHZ) / 1000)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic flash_boot_pin,
    output logic irq,
    output logic [3:0] timer_irq,
    output logic cpu_rst_req,
    output logic core_rst_req,
    output logic sys_rst_req
);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------

    // Address split into region, unit index and word offset.
    wire [4:0] off = paddr[4:0];
    wire [1:0] unit = paddr[6:5];
    wire is_glob = paddr[7] && (unit == 2'h3);
    wire setup = psel && !penable;
    wire wr_en = ce && psel && penable && pwrite && !pslverr;
    wire t_ok = !paddr[7] && (off <= `TGW_TCNH);
    wire w_ok = paddr[7] && (unit != 2'h3);
    wire g_ok = (paddr == `TGW_INT_ST) || (paddr == `TGW_INT_MSK);
    wire map_ok = (paddr[1:0] == 2'h0) && (t_ok || w_ok || g_ok);
    wire glob_wr = wr_en && is_glob;

    logic [31:0] tmr_rd [4];
    logic [31:0] wdt_rd [3];
    logic [3:0] alarm;
    logic [3:0] edge_mode;
    logic [2:0] wd_int;
    logic [2:0] wd_cpu;
    logic [2:0] wd_core;
    logic [2:0] wd_sys;
    logic [6:0] st_reg;
    logic [6:0] msk_reg;
    logic [3:0] alm_q_reg;
    logic [31:0] prdata_next;
    logic s1_reg;
    logic s2_reg;
    logic [1:0] boot_cnt_reg;
    logic boot_load_reg;
    logic rd_ok_reg;

    // A read waits until its data has been captured on a running edge, so a setup
    // cycle lost to a low clock enable never leaves stale data under pready.
    assign pready = ce && (pwrite || rd_ok_reg);
    assign pslverr = psel && penable && !map_ok;

    // ----------------------------------------
    // Flash boot strap
    // ----------------------------------------

    // Strap passes two flip-flops, then is acted on once after reset release.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            boot_cnt_reg <= 2'h0;
            boot_load_reg <= 1'b0;
        end else if (ce) begin
            s1_reg <= flash_boot_pin;
            s2_reg <= s1_reg;
            if (boot_cnt_reg != 2'h3) begin
                boot_cnt_reg <= boot_cnt_reg + 2'h1;
            end
            boot_load_reg <= (boot_cnt_reg == 2'h2) && s2_reg;
        end
    end

    // ----------------------------------------
    // General-purpose timers
    // ----------------------------------------

    for (genvar i = 0; i < 4; i++) begin : g_tmr
        logic [31:0] cfg_reg;
        logic [63:0] load_reg;
        logic [63:0] alm_reg;
        logic [63:0] cnt_reg;
        logic [63:0] cnt_next;
        logic [15:0] pre_reg;
        wire sel = wr_en && !paddr[7] && (unit == 2'(i));
        wire en = cfg_reg[0];
        wire [15:0] div = cfg_reg[31:16];
        wire [15:0] term = (div == 16'h0) ? 16'hffff :
            (div == 16'h1) ? 16'h1 : div - 16'h1;
        wire tick = en && (pre_reg == term);
        wire [63:0] step = cfg_reg[1] ? cnt_reg + 64'h1 : cnt_reg - 64'h1;
        wire hit = tick && cfg_reg[4] && (step == alm_reg);
        wire force_ld = sel && (off == `TGW_TCFG) && pwdata[5];

        always_comb begin
            cnt_next = cnt_reg;
            if (force_ld || (hit && cfg_reg[2])) begin
                cnt_next = load_reg;
            end else if (tick) begin
                cnt_next = step;
            end
        end

        // Register writes, prescaler and counter; a halted timer keeps its prescaler and changes its counter only on a forced load.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_reg <= 32'h0;
                load_reg <= 64'h0;
                alm_reg <= 64'h0;
                cnt_reg <= 64'h0;
                pre_reg <= 16'h0;
            end else if (ce) begin
                if (sel && off == `TGW_TCFG) cfg_reg <= pwdata & `TGW_TCFG_MASK;
                if (sel && off == `TGW_TLDL) load_reg[31:0] <= pwdata;
                if (sel && off == `TGW_TLDH) load_reg[63:32] <= pwdata;
                if (sel && off == `TGW_TALL) alm_reg[31:0] <= pwdata;
                if (sel && off == `TGW_TALH) alm_reg[63:32] <= pwdata;
                if (en) begin
                    pre_reg <= tick ? 16'h0 : pre_reg + 16'h1;
                end
                cnt_reg <= cnt_next;
            end
        end

        assign alarm[i] = hit;
        assign edge_mode[i] = cfg_reg[3];
        assign tmr_rd[i] = (off == `TGW_TCFG) ? cfg_reg :
            (off == `TGW_TLDL) ? load_reg[31:0] :
            (off == `TGW_TLDH) ? load_reg[63:32] :
            (off == `TGW_TALL) ? alm_reg[31:0] :
            (off == `TGW_TALH) ? alm_reg[63:32] :
            (off == `TGW_TCNL) ? cnt_reg[31:0] :
            (off == `TGW_TCNH) ? cnt_reg[63:32] : 32'h0;
    end

    // ----------------------------------------
    // Watchdogs
    // ----------------------------------------

    for (genvar w = 0; w < 3; w++) begin : g_wdt
        logic [12:0] cfg_reg;
        logic [31:0] to_reg [4];
        logic unl_reg;
        logic [1:0] stg_reg;
        logic [31:0] cnt_reg;
        wire sel = wr_en && paddr[7] && (unit == 2'(w));
        wire cfg_wr = sel && unl_reg;
        wire feed = sel && (off == `TGW_WFEED);
        wire st_en = cfg_reg[3'(1) + 3'(stg_reg)];
        wire [1:0] act = cfg_reg[5 + 2 * stg_reg +: 2];
        wire [32:0] nxt = {1'b0, cnt_reg} + 33'h1;
        wire expd = cfg_reg[0] && st_en && !feed && (nxt >= {1'b0, to_reg[stg_reg]});
        wire boot = boot_load_reg && (w != 1);

        // Configuration, protection and timeouts.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_reg <= 13'h0;
                unl_reg <= 1'b0;
                for (int s = 0; s < 4; s++) begin
                    to_reg[s] <= 32'h0;
                end
            end else if (ce) begin
                if (boot) begin
                    cfg_reg <= (w == 2) ? `TGW_BOOT_CFG_SYS : `TGW_BOOT_CFG_CORE;
                    to_reg[0] <= BOOT_TO;
                end else if (cfg_wr && off == `TGW_WCFG) begin
                    cfg_reg <= pwdata[12:0];
                end
                for (int s = 0; s < 4; s++) begin
                    if (cfg_wr && !boot && off == `TGW_WTO0 + 5'(4 * s)) to_reg[s] <= pwdata;
                end
                if (sel && off == `TGW_WPROT) unl_reg <= (pwdata == `TGW_WKEY);
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stg_reg <= 2'h0;
                cnt_reg <= 32'h0;
            end else if (ce) begin
                if (feed || !cfg_reg[0]) begin
                    stg_reg <= 2'h0;
                    cnt_reg <= 32'h0;
                end else if (expd || !st_en) begin
                    stg_reg <= stg_reg + 2'h1;
                    cnt_reg <= 32'h0;
                end else begin
                    cnt_reg <= nxt[31:0];
                end
            end
        end

        assign wd_int[w] = expd && (act == tgw_pkg::TGW_ACT_INT);
        assign wd_cpu[w] = expd && (act == tgw_pkg::TGW_ACT_CPU);
        assign wd_core[w] = expd && (act == tgw_pkg::TGW_ACT_CORE);
        assign wd_sys[w] = expd && (act == tgw_pkg::TGW_ACT_SYS) && (w == 2);
        assign wdt_rd[w] = (off == `TGW_WCFG) ? {19'h0, cfg_reg} :
            (off == `TGW_WTO0) ? to_reg[0] :
            (off == `TGW_WTO0 + 5'h4) ? to_reg[1] :
            (off == `TGW_WTO0 + 5'h8) ? to_reg[2] :
            (off == `TGW_WTO0 + 5'hc) ? to_reg[3] :
            (off == `TGW_WPROT) ? {31'h0, !unl_reg} :
            (off == `TGW_WSTAT) ? {cnt_reg[29:0], stg_reg} : 32'h0;
    end

    // ----------------------------------------
    // Interrupts, resets and read data
    // ----------------------------------------

    // Sticky status: a new event wins over a write-one clear.
    wire [6:0] ev = {wd_int, alarm};
    wire [6:0] clr = (glob_wr && paddr == `TGW_INT_ST) ? pwdata[6:0] : 7'h0;

    // Read data is captured on the first running edge of a read and held to its end.
    always_comb begin
        prdata_next = 32'h0;
        if (!paddr[7]) begin
            prdata_next = tmr_rd[unit];
        end else if (!is_glob) begin
            prdata_next = wdt_rd[unit];
        end else if (paddr == `TGW_INT_ST) begin
            prdata_next = {25'h0, st_reg};
        end else if (paddr == `TGW_INT_MSK) begin
            prdata_next = {25'h0, msk_reg};
        end
    end

    // Status, mask, alarm pulses and reset request pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= 7'h0;
            msk_reg <= 7'h0;
            alm_q_reg <= 4'h0;
            prdata <= 32'h0;
            cpu_rst_req <= 1'b0;
            core_rst_req <= 1'b0;
            sys_rst_req <= 1'b0;
            rd_ok_reg <= 1'b0;
        end else if (ce) begin
            st_reg <= (st_reg & ~clr) | ev;
            if (glob_wr && paddr == `TGW_INT_MSK) msk_reg <= pwdata[6:0];
            alm_q_reg <= alarm;
            if (psel && !pwrite && !rd_ok_reg) prdata <= prdata_next;
            if (psel && penable && pready) begin
                rd_ok_reg <= 1'b0;
            end else if (psel && !pwrite) begin
                rd_ok_reg <= 1'b1;
            end
            cpu_rst_req <= |wd_cpu;
            core_rst_req <= |wd_core;
            sys_rst_req <= |wd_sys;
        end
    end

    assign timer_irq = (edge_mode & alm_q_reg) | (~edge_mode & st_reg[3:0]);
    assign irq = |(st_reg & msk_reg);

endmodule

// ### testbench/tgw_chk.sv
// Purpose: Port-level checks of the timer group block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to the top module from the bench file.
`timescale 1ns/1ps
module tgw_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic flash_boot_pin,
    input wire logic irq,
    input wire logic [3:0] timer_irq,
    input wire logic cpu_rst_req,
    input wire logic core_rst_req,
    input wire logic sys_rst_req
);
    // ----------------------------------------
    // Bus and output checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Read setup cycles and the unmapped top of the map.
    wire rd_setup = psel && !penable && !pwrite && ce;
    wire unmapped = paddr >= 8'he8;
    pready_ce_a: assert property (pready |-> ce)
        else $error("pready high while ce was low.");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside an access phase.");
    err_align_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused.");
    err_unmap_a: assert property (psel && penable && unmapped |-> pslverr)
        else $error("unmapped access not refused.");
    err_rdata_a: assert property (rd_setup && unmapped |=> prdata == 32'h0)
        else $error("refused read returned data.");
    rdata_hold_a: assert property (!(psel && !pwrite && ce) |=> $stable(prdata))
        else $error("read data changed without a read.");
    freeze_a: assert property (!ce |=> $stable({irq, timer_irq, cpu_rst_req, sys_rst_req}))
        else $error("outputs moved while ce was low.");
    boot_quiet_a: assert property ($rose(presetn) |-> !sys_rst_req [*4])
        else $error("system reset request right after reset.");
    cpu_pulse_a: assert property ($rose(cpu_rst_req) |=> !cpu_rst_req)
        else $error("processor reset request longer than one cycle.");
    sys_pulse_a: assert property ($rose(sys_rst_req) |=> !sys_rst_req)
        else $error("system reset request longer than one cycle.");
endmodule

// ### testbench/tb.sv
// Purpose: Self-checking bench of the timer group block.
// Assumes: The bench is the APB master and drives every input itself.
// Notes: Reads queue their expected {pslverr, prdata}; a monitor compares them.
`timescale 1ns/1ps
`include "tgw_map.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
bind tgw_timer_group_watchdog tgw_chk chk (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_boot_pin(flash_boot_pin),
    .irq(irq), .timer_irq(timer_irq), .cpu_rst_req(cpu_rst_req),
    .core_rst_req(core_rst_req), .sys_rst_req(sys_rst_req));
module tb;
    // ----------------------------------------
    // Signals, design and clock
    // ----------------------------------------
    localparam logic [31:0] BT = 32'h32;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic flash_boot_pin = 0, ce_rand = 0;
    logic [7:0] paddr = 8'h0, b;
    logic [31:0] pwdata = 32'h0, prdata, l, h, a;
    logic pready, pslverr, irq, cpu_rst_req, core_rst_req, sys_rst_req;
    logic [3:0] timer_irq;
    logic [32:0] expq[$];
    logic [32:0] e;
    int fail_count = 0, n_compared = 0, n, t0, t1, t2, ns, nc;
    tgw_timer_group_watchdog #(.BOOT_TO(BT)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_boot_pin(flash_boot_pin),
        .irq(irq), .timer_irq(timer_irq), .cpu_rst_req(cpu_rst_req),
        .core_rst_req(core_rst_req), .sys_rst_req(sys_rst_req));
    always #5 pclk = ~pclk;
    // Random clock-enable gaps stretch transfers while ce_rand is set.
    always @(posedge pclk) ce <= ce_rand ? 1'($urandom) : 1'b1;
    // Each completed read takes the oldest expected value off the queue.
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e = expq.pop_front();
            `CHK("read", e, {pslverr, prdata})
        end
    end
    // One transfer: setup, access until pready, then an idle cycle.
    task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= ad;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(ad, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [32:0] x);
        expq.push_back(x);
        apb(ad, 1'b0, 32'h0);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        close_out();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h861f));
        t0 = 6 + int'($urandom_range(7));
        t1 = 3 + int'($urandom_range(9));
        t2 = 3 + int'($urandom_range(9));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        ce_rand <= 1'b1;
        rd(`TGW_INT_ST, 33'h0);
        rd(8'hb8, 33'h1);
        rd(8'hfc, {1'b1, 32'h0});
        rd(8'h06, {1'b1, 32'h0});
        wr(8'hb8, `TGW_WKEY);
        wr(8'ha4, 32'(t0));
        wr(8'hb8, 32'h0);
        wr(8'ha4, 32'hff);
        rd(8'ha4, {1'b0, 32'(t0)});
        rd(8'hb8, 33'h1);
        wr(8'hb8, `TGW_WKEY);
        wr(8'ha8, 32'(t1));
        wr(8'hac, 32'(t2));
        ce_rand <= 1'b0;
        wr(`TGW_INT_MSK, 32'h20);
        // Stages: interrupt, system (no effect here), processor reset.
        wr(8'ha0, 32'h38f);
        repeat (6) wr(8'hb4, 32'h0);
        rd(`TGW_INT_ST, 33'h0);
        n = 0;
        ns = 0;
        nc = 0;
        while (cpu_rst_req !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
            if (irq === 1'b1 && ns == 0) ns = n;
            if (sys_rst_req === 1'b1) nc = 1;
        end
        `CHK("wd_int", 1'b1, ns >= t0 - 7 && ns <= t0)
        `CHK("wd_cpu", 1'b1, n >= t0 + t1 + t2 - 7 && n <= t0 + t1 + t2)
        `CHK("wd_sys", 1'b1, nc == 0)
        wr(8'ha0, 32'h0);
        wr(`TGW_INT_ST, 32'h20);
        @(negedge pclk);
        `CHK("wd_clr", 1'b0, irq)
        @(posedge pclk);
        // Timer 0 counts up in level mode, timer 1 down in pulse mode.
        for (int i = 0; i < 2; i++) begin
            b = 8'(i * 32);
            l = 32'h100 + ($urandom & 32'hffff);
            h = $urandom;
            a = (i == 0) ? l + 32'h2 : l - 32'h2;
            wr(b + 8'h04, l);
            wr(b + 8'h08, h);
            wr(b, 32'h20);
            rd(b + 8'h14, {1'b0, l});
            rd(b + 8'h18, {1'b0, h});
            wr(b + 8'h0c, a);
            wr(b + 8'h10, h);
            wr(b, {16'(2 + i), 16'h0011} | (i == 0 ? 32'h2 : 32'h8));
            n = 0;
            while (timer_irq[i] !== 1'b1 && n < 60) begin
                @(posedge pclk);
                n++;
            end
            `CHK("alarm", 1'b1, n >= 1 + 3 * i && n <= 5 + 3 * i)
            @(negedge pclk);
            `CHK("shape", 1'(i == 0), timer_irq[i])
            `CHK("masked", 1'b0, irq)
            @(posedge pclk);
            wr(b, 32'h0);
            wr(`TGW_INT_MSK, 32'(1 << i));
            @(negedge pclk);
            `CHK("unmask", 1'b1, irq)
            @(posedge pclk);
            wr(`TGW_INT_ST, 32'(1 << i));
            @(negedge pclk);
            `CHK("clear", 1'b0, irq)
            @(posedge pclk);
            wr(`TGW_INT_MSK, 32'h0);
        end
        // Flash boot: both supervising watchdogs start without software.
        presetn <= 1'b0;
        flash_boot_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        ns = 0;
        nc = 0;
        for (int k = 1; k <= BT + 20; k++) begin
            @(posedge pclk);
            if (sys_rst_req === 1'b1 && ns == 0) ns = k;
            if (core_rst_req === 1'b1 && nc == 0) nc = k;
        end
        `CHK("boot_sys", 1'b1, ns >= BT && ns <= BT + 10)
        `CHK("boot_core", 1'b1, nc >= BT && nc <= BT + 10)
        close_out();
    end
endmodule
